// File: core/nrtx_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "nrtx_defines.vh"
module nrtx_exec (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_valid,
  input wire [9:0] i_opcode,
  input wire [2:0] i_stack_level_pointer,
  input wire i_carry_flag,
  input wire i_ram_we,
  input wire [7:0] i_ram_addr,
  input wire [3:0] i_ram_wdata,
  output wire [3:0] o_ram_rdata,
  output reg [3:0] o_a,
  output reg [3:0] o_b,
  output reg [3:0] o_x,
  output reg [3:0] o_y,
  output reg [1:0] o_z,
  output reg [2:0] o_d,
  output reg [7:0] o_e,
  output reg o_carry_flag,
  output reg o_skip,
  output wire o_handled
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [4:0] cls;
  nrtx_decode u_dec (
    .i_opcode(i_opcode),
    .o_class(cls)
  );
  assign o_handled = i_valid && (cls != `NRTX_CL_NONE);
  wire [3:0] fx = i_opcode[7:4];
  wire [3:0] fy = i_opcode[3:0];
  wire [3:0] fj = i_opcode[3:0];
  wire [1:0] fz = i_opcode[1:0];
  // ----------------------------------------------------------------
  // skip state
  // ----------------------------------------------------------------
  reg skip_r;
  reg last_pair_r;
  wire is_pair = (cls == `NRTX_CL_PPL);
  wire pair_skip = is_pair && last_pair_r;
  wire run = i_valid && !skip_r && !pair_skip;
  // ----------------------------------------------------------------
  // ram port, pointer from x y
  // ----------------------------------------------------------------
  reg mem_we;
  reg [3:0] mem_wd;
  wire [3:0] mem_rd;
  wire [7:0] dp = {o_x, o_y};
  nrtx_ram u_ram (
    .i_sys_clk(i_sys_clk),
    .i_addr(i_valid ? dp : i_ram_addr),
    .i_we(i_valid ? mem_we : i_ram_we),
    .i_wdata(i_valid ? mem_wd : i_ram_wdata),
    .o_rdata(mem_rd)
  );
  assign o_ram_rdata = mem_rd;
  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  reg [3:0] a_nxt;
  reg [3:0] b_nxt;
  reg [3:0] x_nxt;
  reg [3:0] y_nxt;
  reg [1:0] z_nxt;
  reg [2:0] d_nxt;
  reg [7:0] e_nxt;
  reg skip_nxt;
  wire [3:0] y_inc = o_y + `NRTX_NIB_ONE;
  wire [3:0] y_dec = o_y - `NRTX_NIB_ONE;
  always @* begin
    a_nxt = o_a;
    b_nxt = o_b;
    x_nxt = o_x;
    y_nxt = o_y;
    z_nxt = o_z;
    d_nxt = o_d;
    e_nxt = o_e;
    skip_nxt = 1'b0;
    mem_we = 1'b0;
    mem_wd = o_a;
    if (run) begin
      case (cls)
        `NRTX_CL_TAB: a_nxt = o_b;
        `NRTX_CL_TBA: b_nxt = o_a;
        `NRTX_CL_TAY: a_nxt = o_y;
        `NRTX_CL_TYA: y_nxt = o_a;
        `NRTX_CL_TEAB: e_nxt = {o_b, o_a};
        `NRTX_CL_TABE: begin
          b_nxt = o_e[7:4];
          a_nxt = o_e[3:0];
        end
        `NRTX_CL_TDA: d_nxt = o_a[2:0];
        `NRTX_CL_TAD: a_nxt = {1'b0, o_d};
        `NRTX_CL_TAZ: a_nxt = {2'b00, o_z};
        `NRTX_CL_TAX: a_nxt = o_x;
        `NRTX_CL_TASP: a_nxt = {1'b0, i_stack_level_pointer};
        `NRTX_CL_PPL: begin
          x_nxt = fx;
          y_nxt = fy;
        end
        `NRTX_CL_LZ: z_nxt = fz;
        `NRTX_CL_INY: begin
          y_nxt = y_inc;
          skip_nxt = (y_inc == `NRTX_NIB_ZERO);
        end
        `NRTX_CL_DEY: begin
          y_nxt = y_dec;
          skip_nxt = (y_dec == `NRTX_NIB_MAX);
        end
        `NRTX_CL_TAM: begin
          a_nxt = mem_rd;
          x_nxt = o_x ^ fj;
        end
        `NRTX_CL_XAM: begin
          a_nxt = mem_rd;
          mem_we = 1'b1;
          x_nxt = o_x ^ fj;
        end
        `NRTX_CL_XAMD: begin
          a_nxt = mem_rd;
          mem_we = 1'b1;
          x_nxt = o_x ^ fj;
          y_nxt = y_dec;
          skip_nxt = (y_dec == `NRTX_NIB_MAX);
        end
        `NRTX_CL_XAMI: begin
          a_nxt = mem_rd;
          mem_we = 1'b1;
          x_nxt = o_x ^ fj;
          y_nxt = y_inc;
          skip_nxt = (y_inc == `NRTX_NIB_ZERO);
        end
        `NRTX_CL_TMA: begin
          mem_we = 1'b1;
          x_nxt = o_x ^ fj;
        end
        default: a_nxt = o_a;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_a <= `NRTX_NIB_RST;
      o_b <= `NRTX_NIB_RST;
      o_x <= `NRTX_NIB_RST;
      o_y <= `NRTX_NIB_RST;
      o_z <= `NRTX_Z_RST;
      o_d <= `NRTX_D_RST;
      o_e <= `NRTX_E_RST;
      o_carry_flag <= 1'b0;
      o_skip <= 1'b0;
      skip_r <= 1'b0;
      last_pair_r <= 1'b0;
    end else begin
      // carry follows the core; these instructions never touch it
      o_carry_flag <= i_carry_flag;
      if (i_valid) begin
        o_a <= a_nxt;
        o_b <= b_nxt;
        o_x <= x_nxt;
        o_y <= y_nxt;
        o_z <= z_nxt;
        o_d <= d_nxt;
        o_e <= e_nxt;
        skip_r <= skip_nxt;
        o_skip <= skip_nxt;
        last_pair_r <= is_pair;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/nrtx_defines.vh
// Function
// - copy B into A, B unchanged
// - copy A into B, A unchanged
// - copy Y into A
// - copy A into Y
// - E gets B in upper nibble, A in lower nibble
// - B gets E upper nibble, A gets E lower nibble
// - D gets low three bits of A
// - A gets D in low three bits, top bit cleared
// - A gets Z in low two bits, upper two cleared
// - copy X into A
// - A gets stack level pointer in low bits, top bit cleared
// - pointer pair load writes x to X and y to Y
// - consecutive pointer pair loads after the first are skipped
// - immediate Z load writes z into Z
// - increment Y, skip next when result is zero
// - decrement Y, skip next when result is fifteen
// - load A from RAM at pointer, then X ^= j
// - swap A with RAM at pointer, then X ^= j
// - swap, X ^= j, decrement Y, skip when Y becomes fifteen
// - swap, X ^= j, increment Y, skip when Y becomes zero
// - store A to RAM at pointer, then X ^= j
`ifndef NRTX_DEFINES_VH
`define NRTX_DEFINES_VH
// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define NRTX_OP_TAB 10'h01e
`define NRTX_OP_TBA 10'h00e
`define NRTX_OP_TAY 10'h01f
`define NRTX_OP_TYA 10'h00c
`define NRTX_OP_TEAB 10'h01a
`define NRTX_OP_TABE 10'h02a
`define NRTX_OP_TDA 10'h029
`define NRTX_OP_TAD 10'h051
`define NRTX_OP_TAZ 10'h053
`define NRTX_OP_TAX 10'h052
`define NRTX_OP_TASP 10'h050
`define NRTX_OP_INY 10'h013
`define NRTX_OP_DEY 10'h017
// masks and patterns for field forms
`define NRTX_PPL_MASK 10'h300
`define NRTX_PPL_PAT 10'h300
`define NRTX_LZ_MASK 10'h3fc
`define NRTX_LZ_PAT 10'h048
`define NRTX_J_MASK 10'h3f0
`define NRTX_TAM_PAT 10'h2c0
`define NRTX_XAM_PAT 10'h2d0
`define NRTX_XAMD_PAT 10'h2f0
`define NRTX_XAMI_PAT 10'h2e0
`define NRTX_TMA_PAT 10'h2b0
// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define NRTX_NIB_RST 4'h0
`define NRTX_D_RST 3'h0
`define NRTX_Z_RST 2'h0
`define NRTX_E_RST 8'h00
`define NRTX_NIB_ONE 4'h1
`define NRTX_NIB_ZERO 4'h0
`define NRTX_NIB_MAX 4'hf
`define NRTX_RAM_DEPTH 256
// decode class codes
`define NRTX_CL_NONE 5'h00
`define NRTX_CL_TAB 5'h01
`define NRTX_CL_TBA 5'h02
`define NRTX_CL_TAY 5'h03
`define NRTX_CL_TYA 5'h04
`define NRTX_CL_TEAB 5'h05
`define NRTX_CL_TABE 5'h06
`define NRTX_CL_TDA 5'h07
`define NRTX_CL_TAD 5'h08
`define NRTX_CL_TAZ 5'h09
`define NRTX_CL_TAX 5'h0a
`define NRTX_CL_TASP 5'h0b
`define NRTX_CL_PPL 5'h0c
`define NRTX_CL_LZ 5'h0d
`define NRTX_CL_INY 5'h0e
`define NRTX_CL_DEY 5'h0f
`define NRTX_CL_TAM 5'h10
`define NRTX_CL_XAM 5'h11
`define NRTX_CL_XAMD 5'h12
`define NRTX_CL_XAMI 5'h13
`define NRTX_CL_TMA 5'h14
`endif

// File: core/nrtx_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "nrtx_defines.vh"
module nrtx_decode (
  input wire [9:0] i_opcode,
  output reg [4:0] o_class
);
  // ----------------------------------------------------------------
  // field form match
  // ----------------------------------------------------------------
  function is_form;
    input [9:0] op;
    input [9:0] mask;
    input [9:0] pat;
    begin
      is_form = ((op & mask) == pat);
    end
  endfunction
  always @* begin
    o_class = `NRTX_CL_NONE;
    if (is_form(i_opcode, `NRTX_PPL_MASK, `NRTX_PPL_PAT)) begin
      o_class = `NRTX_CL_PPL;
    end else if (is_form(i_opcode, `NRTX_LZ_MASK, `NRTX_LZ_PAT)) begin
      o_class = `NRTX_CL_LZ;
    end else if (is_form(i_opcode, `NRTX_J_MASK, `NRTX_TAM_PAT)) begin
      o_class = `NRTX_CL_TAM;
    end else if (is_form(i_opcode, `NRTX_J_MASK, `NRTX_XAM_PAT)) begin
      o_class = `NRTX_CL_XAM;
    end else if (is_form(i_opcode, `NRTX_J_MASK, `NRTX_XAMD_PAT)) begin
      o_class = `NRTX_CL_XAMD;
    end else if (is_form(i_opcode, `NRTX_J_MASK, `NRTX_XAMI_PAT)) begin
      o_class = `NRTX_CL_XAMI;
    end else if (is_form(i_opcode, `NRTX_J_MASK, `NRTX_TMA_PAT)) begin
      o_class = `NRTX_CL_TMA;
    end else begin
      case (i_opcode)
        `NRTX_OP_TAB: o_class = `NRTX_CL_TAB;
        `NRTX_OP_TBA: o_class = `NRTX_CL_TBA;
        `NRTX_OP_TAY: o_class = `NRTX_CL_TAY;
        `NRTX_OP_TYA: o_class = `NRTX_CL_TYA;
        `NRTX_OP_TEAB: o_class = `NRTX_CL_TEAB;
        `NRTX_OP_TABE: o_class = `NRTX_CL_TABE;
        `NRTX_OP_TDA: o_class = `NRTX_CL_TDA;
        `NRTX_OP_TAD: o_class = `NRTX_CL_TAD;
        `NRTX_OP_TAZ: o_class = `NRTX_CL_TAZ;
        `NRTX_OP_TAX: o_class = `NRTX_CL_TAX;
        `NRTX_OP_TASP: o_class = `NRTX_CL_TASP;
        `NRTX_OP_INY: o_class = `NRTX_CL_INY;
        `NRTX_OP_DEY: o_class = `NRTX_CL_DEY;
        default: o_class = `NRTX_CL_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: core/nrtx_ram.v
`timescale 1ns/1ps
`default_nettype none
`include "nrtx_defines.vh"
module nrtx_ram (
  input wire i_sys_clk,
  input wire [7:0] i_addr,
  input wire i_we,
  input wire [3:0] i_wdata,
  output wire [3:0] o_rdata
);
  // ----------------------------------------------------------------
  // nibble store, combinational read
  // ----------------------------------------------------------------
  reg [3:0] mem [0:`NRTX_RAM_DEPTH-1];
  assign o_rdata = mem[i_addr];
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// File: verif/nrtx_exec_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "nrtx_defines.vh"
module nrtx_exec_sva (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [9:0] i_opcode,
  input wire logic i_carry_flag,
  input wire logic [3:0] o_a,
  input wire logic [3:0] o_b,
  input wire logic [3:0] o_x,
  input wire logic [3:0] o_y,
  input wire logic [7:0] o_e,
  input wire logic [2:0] o_d,
  input wire logic [1:0] o_z,
  input wire logic o_carry_flag,
  input wire logic o_skip
);
  // ----------------------------------------------------------------
  // pointer pair chain tracking
  // ----------------------------------------------------------------
  logic pair_r;
  wire pair = i_opcode[9:8] == 2'b11;
  wire go = i_valid && !o_skip && !(pair && pair_r);
  wire jform = i_opcode[9:6] == 4'hb || i_opcode[9:4] == 6'h2b;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst)
      pair_r <= 1'b0;
    else if (i_valid)
      pair_r <= pair;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_iny;
    go && i_opcode == `NRTX_OP_INY;
  endsequence
  sequence s_dey;
    go && i_opcode == `NRTX_OP_DEY;
  endsequence
  sequence s_xamd;
    go && (i_opcode & `NRTX_J_MASK) == `NRTX_XAMD_PAT;
  endsequence
  sequence s_xami;
    go && (i_opcode & `NRTX_J_MASK) == `NRTX_XAMI_PAT;
  endsequence
  a_tab_copy: assert property (
    go && i_opcode == `NRTX_OP_TAB |=> o_a == $past(o_b) && $stable(o_b))
    else $error("a from b wrong");
  a_teab_pack: assert property (
    go && i_opcode == `NRTX_OP_TEAB |=> o_e == {$past(o_b), $past(o_a)})
    else $error("e pack wrong");
  a_tad_top_zero: assert property (
    go && i_opcode == `NRTX_OP_TAD |=> o_a == {1'b0, $past(o_d)})
    else $error("a from d wrong");
  a_pair_load: assert property (
    go && pair |=> o_x == $past(i_opcode[7:4]) && o_y == $past(i_opcode[3:0]))
    else $error("pointer pair load wrong");
  a_pair_chain: assert property (
    i_valid && pair && pair_r |=> $stable({o_x, o_y}))
    else $error("chained pointer load not skipped");
  a_iny_skip: assert property (
    s_iny |=> o_y == $past(o_y) + 4'h1 && o_skip == (o_y == 4'h0))
    else $error("increment or skip wrong");
  a_dey_skip: assert property (
    s_dey |=> o_y == $past(o_y) - 4'h1 && o_skip == (o_y == 4'hf))
    else $error("decrement or skip wrong");
  a_xamd_skip: assert property (
    s_xamd |=> o_y == $past(o_y) - 4'h1 && o_skip == (o_y == 4'hf))
    else $error("exchange decrement or skip wrong");
  a_xami_skip: assert property (
    s_xami |=> o_y == $past(o_y) + 4'h1 && o_skip == (o_y == 4'h0))
    else $error("exchange increment or skip wrong");
  a_x_xor: assert property (
    go && jform |=> o_x == ($past(o_x) ^ $past(i_opcode[3:0])))
    else $error("x update wrong");
  a_carry_hold: assert property (
    go |=> o_carry_flag == $past(i_carry_flag))
    else $error("carry changed");
  a_skip_quiet: assert property (
    i_valid && o_skip |=> $stable({o_a, o_b, o_x, o_y, o_e, o_d, o_z}))
    else $error("skipped slot changed state");
endmodule
bind nrtx_exec nrtx_exec_sva i_sva (.i_sys_clk, .i_nrst, .i_valid,
  .i_opcode, .i_carry_flag, .o_a, .o_b, .o_x, .o_y, .o_e, .o_d, .o_z,
  .o_carry_flag, .o_skip);
`default_nettype wire

// File: verif/nrtx_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module nrtx_exec_test;
  logic i_sys_clk, i_nrst, i_valid, i_carry_flag, i_ram_we;
  logic [9:0] i_opcode;
  logic [2:0] i_stack_level_pointer, o_d;
  logic [7:0] i_ram_addr, o_e;
  logic [3:0] i_ram_wdata, o_ram_rdata, o_a, o_b, o_x, o_y;
  logic [1:0] o_z;
  logic o_carry_flag, o_skip, o_handled;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [40:0] rows [14];
  wire [30:0] st = {o_a, o_b, o_x, o_y, o_e, o_d, o_z, o_carry_flag, o_skip};
  nrtx_exec i_nrtx_exec (.i_sys_clk, .i_nrst, .i_valid, .i_opcode,
    .i_stack_level_pointer, .i_carry_flag, .i_ram_we, .i_ram_addr,
    .i_ram_wdata, .o_ram_rdata, .o_a, .o_b, .o_x, .o_y, .o_z, .o_d, .o_e,
    .o_carry_flag, .o_skip, .o_handled);
  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic op(input logic [9:0] c);
    @(negedge i_sys_clk);
    i_valid = 1'b1;
    i_opcode = c;
    @(negedge i_sys_clk);
    i_valid = 1'b0;
  endtask
  task automatic pre(input logic [7:0] ad, input logic [3:0] d);
    @(negedge i_sys_clk);
    i_ram_we = 1'b1;
    i_ram_addr = ad;
    i_ram_wdata = d;
    @(negedge i_sys_clk);
    i_ram_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [3:0] d);
    @(negedge i_sys_clk);
    i_ram_addr = ad;
    #1;
    chk(o_ram_rdata, d);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_nrst = 1'b0;
    i_valid = 1'b0;
    i_opcode = 10'h000;
    i_stack_level_pointer = 3'h6;
    i_carry_flag = 1'b1;
    i_ram_we = 1'b0;
    i_ram_addr = 8'h00;
    i_ram_wdata = 4'h0;
    rows = '{
      {10'h335, 16'h0035, 8'h00, 3'h0, 2'h0, 2'b10},
      {10'h399, 16'h0035, 8'h00, 3'h0, 2'h0, 2'b10},
      {10'h052, 16'h3035, 8'h00, 3'h0, 2'h0, 2'b10},
      {10'h00e, 16'h3335, 8'h00, 3'h0, 2'h0, 2'b10},
      {10'h01f, 16'h5335, 8'h00, 3'h0, 2'h0, 2'b10},
      {10'h01a, 16'h5335, 8'h35, 3'h0, 2'h0, 2'b10},
      {10'h04a, 16'h5335, 8'h35, 3'h0, 2'h2, 2'b10},
      {10'h053, 16'h2335, 8'h35, 3'h0, 2'h2, 2'b10},
      {10'h00c, 16'h2332, 8'h35, 3'h0, 2'h2, 2'b10},
      {10'h050, 16'h6332, 8'h35, 3'h0, 2'h2, 2'b10},
      {10'h029, 16'h6332, 8'h35, 3'h6, 2'h2, 2'b10},
      {10'h01e, 16'h3332, 8'h35, 3'h6, 2'h2, 2'b10},
      {10'h051, 16'h6332, 8'h35, 3'h6, 2'h2, 2'b10},
      {10'h02a, 16'h5332, 8'h35, 3'h6, 2'h2, 2'b10}
    };
    repeat (3) @(negedge i_sys_clk);
    chk(st, 32'h0);
    i_nrst = 1'b1;
    foreach (rows[k]) begin
      @(negedge i_sys_clk);
      if (k > 0)
        chk(st, rows[k-1][30:0]);
      i_valid = 1'b1;
      i_opcode = rows[k][40:31];
      #1;
      chk(o_handled, 1'b1);
    end
    @(negedge i_sys_clk);
    chk(st, rows[13][30:0]);
    i_valid = 1'b0;
    i_carry_flag = 1'b0;
    pre(8'h32, 4'h9);
    pre(8'hd3, 4'h7);
    pre(8'h00, 4'h4);
    pre(8'h0f, 4'hb);
    op(10'h2e1);
    chk({o_a, o_x, o_y, o_skip}, 13'h1246);
    op(10'h2bf);
    chk(o_x, 4'hd);
    rd(8'h23, 4'h9);
    rd(8'h32, 4'h5);
    op(10'h2c0);
    chk({o_a, o_x}, 8'h7d);
    op(10'h300);
    op(10'h017);
    chk({o_y, o_skip}, 5'h1f);
    op(10'h01e);
    chk({o_a, o_skip}, 5'h0e);
    op(10'h013);
    chk({o_y, o_skip}, 5'h01);
    op(10'h00e);
    chk(o_b, 4'h3);
    op(10'h2f0);
    chk({o_a, o_y, o_skip}, 9'h09f);
    op(10'h2d0);
    chk(o_a, 4'h4);
    op(10'h2d0);
    chk(o_a, 4'hb);
    rd(8'h0f, 4'h4);
    rd(8'h00, 4'h7);
    @(negedge i_sys_clk);
    i_valid = 1'b1;
    i_opcode = 10'h000;
    #1;
    chk(o_handled, 1'b0);
    @(negedge i_sys_clk);
    i_valid = 1'b0;
    chk({o_a, o_b, o_x, o_y, o_e}, 24'hb30f35);
    chk(o_handled, 1'b0);
    chk(o_carry_flag, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
